// ==== hw/phy_regs_pkg.sv ====
// shared constants for the per-port phy basic control and status registers
package phy_regs_pkg;

    // management frame fields
    localparam int PREAMBLE_ONES = 32;
    localparam int HDR_BITS = 14;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] FRAME_START = 2'b01;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;

    // management register indices
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;

    // basic control field positions
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_FORCE_100 = 13;
    localparam int CTL_AUTONEG_ENABLE = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_AUTONEG_RESTART = 9;
    localparam int CTL_FULL_DUPLEX = 8;
    localparam int CTL_ALT_XOVER = 5;
    localparam int CTL_FORCE_STRAIGHT = 4;
    localparam int CTL_XOVER_DISABLE = 3;
    localparam int CTL_FEF_DISABLE = 2;
    localparam int CTL_TX_DISABLE = 1;
    localparam int CTL_LED_DISABLE = 0;

    // basic control reset value and writable bits
    localparam logic [15:0] CTL_RESET = 16'h1020;
    localparam logic [15:0] CTL_WMASK_FEF = 16'h7b3f;
    localparam logic [15:0] CTL_WMASK_NO_FEF = 16'h7b3b;
    localparam logic [15:0] CTL_RESTART_MASK = 16'h0200;

    // basic status: bits 14..12 capable, 15 not four-pair capable
    localparam logic [15:0] STATUS_VALUE = 16'h7000;

    // switch-side register addresses, index 0 = port one, 1 = port two
    localparam logic [7:0] SW_PHY_BASE_ADDR = 8'h0f;
    localparam logic [7:0] SW_AN_ADDR [2] = '{8'h1c, 8'h2c};
    localparam logic [7:0] SW_CTL_ADDR [2] = '{8'h1d, 8'h2d};
    localparam logic [7:0] SW_XOVER_ADDR [2] = '{8'h1f, 8'h2f};
    localparam int SW_PHY_BASE_LSB = 3;
    localparam logic [4:0] PHY_BASE_RESET = 5'h01;

    typedef enum logic [2:0] {S_IDLE, S_HDR, S_TA, S_DATA} frame_state_t;

endpackage

// ==== hw/bit_sync.sv ====
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== hw/phy_port_ctrl.sv ====
// basic control register image of one phy port with management and switch write paths
`timescale 1ns/1ps
`default_nettype none
module phy_port_ctrl import phy_regs_pkg::*; #(
    parameter bit HAS_FEF = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // management write
    input wire logic mii_wr,
    input wire logic [15:0] mii_wdata,
    // switch-side mirrored writes
    input wire logic sw_wr_an,
    input wire logic sw_wr_ctl,
    input wire logic sw_wr_xover,
    input wire logic [7:0] sw_wdata,
    // control image
    output logic [15:0] ctrl_reg
);
    localparam logic [15:0] WMASK = HAS_FEF ? CTL_WMASK_FEF : CTL_WMASK_NO_FEF;
    logic [15:0] ctrl_next;

    always_comb begin
        // restart is a one-cycle request; a new write in the same cycle still wins
        ctrl_next = ctrl_reg & ~CTL_RESTART_MASK; // see R7
        if (mii_wr) begin
            ctrl_next = (ctrl_next & ~WMASK) | (mii_wdata & WMASK); // see R17
        end
        if (sw_wr_an) begin
            ctrl_next[CTL_AUTONEG_ENABLE] = sw_wdata[7]; // see R5
            ctrl_next[CTL_FORCE_100] = sw_wdata[6]; // see R4
            ctrl_next[CTL_FULL_DUPLEX] = sw_wdata[5]; // see R8
        end
        if (sw_wr_ctl) begin
            ctrl_next[CTL_LOOPBACK] = sw_wdata[0]; // see R2
            ctrl_next[CTL_FORCE_STRAIGHT] = sw_wdata[1]; // see R10
            ctrl_next[CTL_XOVER_DISABLE] = sw_wdata[2]; // see R11
            ctrl_next[CTL_POWER_DOWN] = sw_wdata[3]; // see R6
            ctrl_next[CTL_FEF_DISABLE] = HAS_FEF & sw_wdata[4]; // see R12
            ctrl_next[CTL_AUTONEG_RESTART] = sw_wdata[5]; // see R7
            ctrl_next[CTL_TX_DISABLE] = sw_wdata[6]; // see R13
            ctrl_next[CTL_LED_DISABLE] = sw_wdata[7]; // see R14
        end
        if (sw_wr_xover) begin
            ctrl_next[CTL_ALT_XOVER] = sw_wdata[7]; // see R9
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end
endmodule
`default_nettype wire

// ==== hw/phy_basic_regs.sv ====
// management slave and switch-side mirror for the two phy basic control/status registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Ports answer at phy addresses base and base+1, base one at reset, moved by register 15.
// R2 - Port one loopback (switch register 29 bit 0) wraps port two's receive traffic back out.
// R3 - Port two loopback (switch register 45 bit 0) wraps port one's receive traffic back out.
// R4 - Control bit 13 picks 100 Mbps (1) or 10 Mbps (0), resets to 0, bit 6 of registers 28/44.
// R5 - Control bit 12 enables auto-negotiation, resets to 1, and is bit 7 of registers 28/44.
// R6 - Control bit 11 powers the phy down, resets to 0, and is bit 3 of registers 29/45.
// R7 - Writing 1 to control bit 9 restarts auto-negotiation; it is bit 5 of registers 29/45.
// R8 - Control bit 8 forces full (1) or half (0) duplex, resets to 0, bit 5 of registers 28/44.
// R9 - Control bit 5 picks the alternative crossover, resets to 1, bit 7 of registers 31/47.
// R10 - Control bit 4 transmits on the receive pair, resets to 0, bit 1 of registers 29/45.
// R11 - Control bit 3 disables crossover detection, resets to 0, bit 2 of registers 29/45.
// R12 - Control bit 2 disables far-end fault detection on port one only, as register 29 bit 4.
// R13 - Control bit 1 disables the transmitter, resets to 0, bit 6 of registers 29/45.
// R14 - Control bit 0 turns the LED indications off, resets to 0, bit 7 of registers 29/45.
// R15 - Status bit 15 always reads zero.
// R16 - Status bits 14, 13 and 12 always read one.
// R17 - Control bits 15, 10, 7 and 6 read 0 and ignore writes; mirrored bits change both views.
module phy_basic_regs import phy_regs_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // management serial pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // switch register access
    input wire logic sw_wr_en,
    input wire logic [7:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    output logic [7:0] sw_rd_data,
    // per-port controls, index 0 = port one
    output logic [1:0] far_end_loopback,
    output logic [1:0] force_100,
    output logic [1:0] autoneg_enable,
    output logic [1:0] power_down,
    output logic [1:0] autoneg_restart,
    output logic [1:0] full_duplex,
    output logic [1:0] alt_crossover_algorithm_sel,
    output logic [1:0] force_straight_wiring,
    output logic [1:0] crossover_detect_disable,
    output logic [1:0] tx_disable,
    output logic [1:0] led_disable,
    output logic far_end_fault_disable
);
    logic mdc_s;
    logic mdio_s;
    logic mdc_d_reg;
    logic mdc_rise;
    frame_state_t state_reg;
    logic [5:0] ones_cnt_reg;
    logic [4:0] bit_cnt_reg;
    logic [HDR_BITS-1:0] hdr_reg;
    logic [DATA_BITS-1:0] rd_shift_reg;
    logic [DATA_BITS-1:0] wr_shift_reg;
    logic is_read_reg;
    logic rd_hit_reg;
    logic port_sel_reg;
    logic [1:0] mii_wr_reg;
    logic [15:0] mii_wdata_reg;
    logic [4:0] phy_base_reg;
    logic [15:0] ctrl [2];
    logic [1:0] frame_ok;
    logic [4:0] phy_of_frame;
    logic [4:0] reg_of_frame;
    logic hit_p0;
    logic hit_p1;
    logic frame_hit;
    logic [15:0] sel_ctrl;

    // pins from the host are asynchronous to the core clock
    bit_sync #(
        .W(2)
    ) pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({mdc, mdio_in}),
        .sync_out({mdc_s, mdio_s})
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mdc_d_reg <= 1'b0;
        end else begin
            mdc_d_reg <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_d_reg;

    // header decode: start, opcode, phy address, register index
    assign frame_ok = hdr_reg[13:12] == FRAME_START ? hdr_reg[11:10] : 2'b00;
    assign phy_of_frame = hdr_reg[9:5];
    assign reg_of_frame = hdr_reg[4:0];
    assign hit_p0 = phy_of_frame == phy_base_reg; // see R1
    assign hit_p1 = phy_of_frame == 5'(phy_base_reg + 5'h01); // see R1
    assign frame_hit = (frame_ok == OP_READ || frame_ok == OP_WRITE) && (hit_p0 || hit_p1);
    assign sel_ctrl = hit_p1 ? ctrl[1] : ctrl[0];

    // frame engine: every step happens on a sampled rising edge of mdc
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            ones_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            hdr_reg <= '0;
            is_read_reg <= 1'b0;
            port_sel_reg <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_reg)
                S_IDLE: begin
                    if (mdio_s) begin
                        if (ones_cnt_reg != 6'(PREAMBLE_ONES)) begin
                            ones_cnt_reg <= ones_cnt_reg + 6'h01;
                        end
                    end else if (ones_cnt_reg == 6'(PREAMBLE_ONES)) begin
                        // this zero is the first start bit
                        hdr_reg <= '0;
                        bit_cnt_reg <= 5'h01;
                        state_reg <= S_HDR;
                    end else begin
                        ones_cnt_reg <= '0;
                    end
                end
                S_HDR: begin
                    hdr_reg <= {hdr_reg[HDR_BITS-2:0], mdio_s};
                    ones_cnt_reg <= '0;
                    if (bit_cnt_reg == 5'(HDR_BITS - 1)) begin
                        bit_cnt_reg <= '0;
                        state_reg <= S_TA;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                S_TA: begin
                    if (bit_cnt_reg == '0) begin
                        is_read_reg <= frame_ok == OP_READ;
                        port_sel_reg <= hit_p1 & ~hit_p0;
                        bit_cnt_reg <= 5'h01;
                    end else begin
                        bit_cnt_reg <= '0;
                        state_reg <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (bit_cnt_reg == 5'(DATA_BITS - 1)) begin
                        bit_cnt_reg <= '0;
                        state_reg <= S_IDLE;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // read path: drive zero in the second turnaround bit, then sixteen bits msb first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift_reg <= '0;
            rd_hit_reg <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else if (mdc_rise) begin
            if (state_reg == S_TA && bit_cnt_reg == '0) begin
                rd_hit_reg <= frame_hit && frame_ok == OP_READ; // see R1
                if (frame_hit && frame_ok == OP_READ) begin
                    mdio_out <= 1'b0;
                    mdio_oe_n <= 1'b0;
                    if (reg_of_frame == REG_BASIC_CONTROL) begin
                        rd_shift_reg <= sel_ctrl; // see R17
                    end else if (reg_of_frame == REG_BASIC_STATUS) begin
                        rd_shift_reg <= STATUS_VALUE; // see R15 see R16
                    end else begin
                        rd_shift_reg <= '0;
                    end
                end
            end else if (rd_hit_reg && (state_reg == S_TA || state_reg == S_DATA)) begin
                if (state_reg == S_DATA && bit_cnt_reg == 5'(DATA_BITS - 1)) begin
                    rd_hit_reg <= 1'b0;
                    mdio_out <= 1'b1;
                    mdio_oe_n <= 1'b1;
                end else begin
                    mdio_out <= rd_shift_reg[DATA_BITS-1];
                    rd_shift_reg <= {rd_shift_reg[DATA_BITS-2:0], 1'b0};
                end
            end
        end
    end

    // write path: collect sixteen bits and commit only to a hit basic control register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_shift_reg <= '0;
            mii_wr_reg <= '0;
            mii_wdata_reg <= '0;
        end else begin
            mii_wr_reg <= '0;
            if (mdc_rise && state_reg == S_DATA && !is_read_reg) begin
                wr_shift_reg <= {wr_shift_reg[DATA_BITS-2:0], mdio_s};
                if (bit_cnt_reg == 5'(DATA_BITS - 1) && frame_hit
                        && reg_of_frame == REG_BASIC_CONTROL) begin
                    mii_wdata_reg <= {wr_shift_reg[DATA_BITS-2:0], mdio_s};
                    mii_wr_reg[port_sel_reg] <= 1'b1; // see R1
                end
            end
        end
    end

    // phy address base; port two answers one above port one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phy_base_reg <= PHY_BASE_RESET;
        end else if (sw_wr_en && sw_addr == SW_PHY_BASE_ADDR) begin
            phy_base_reg <= sw_wdata[7:SW_PHY_BASE_LSB]; // see R1
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        phy_port_ctrl #(
            .HAS_FEF(p == 0)
        ) port_ctrl (
            .clock(clock),
            .rst_n(rst_n),
            .mii_wr(mii_wr_reg[p]),
            .mii_wdata(mii_wdata_reg),
            .sw_wr_an(sw_wr_en && sw_addr == SW_AN_ADDR[p]),
            .sw_wr_ctl(sw_wr_en && sw_addr == SW_CTL_ADDR[p]),
            .sw_wr_xover(sw_wr_en && sw_addr == SW_XOVER_ADDR[p]),
            .sw_wdata(sw_wdata),
            .ctrl_reg(ctrl[p])
        );
        assign far_end_loopback[p] = ctrl[p][CTL_LOOPBACK]; // see R2 see R3
        assign force_100[p] = ctrl[p][CTL_FORCE_100];
        assign autoneg_enable[p] = ctrl[p][CTL_AUTONEG_ENABLE];
        assign power_down[p] = ctrl[p][CTL_POWER_DOWN];
        assign autoneg_restart[p] = ctrl[p][CTL_AUTONEG_RESTART];
        assign full_duplex[p] = ctrl[p][CTL_FULL_DUPLEX];
        assign alt_crossover_algorithm_sel[p] = ctrl[p][CTL_ALT_XOVER];
        assign force_straight_wiring[p] = ctrl[p][CTL_FORCE_STRAIGHT];
        assign crossover_detect_disable[p] = ctrl[p][CTL_XOVER_DISABLE];
        assign tx_disable[p] = ctrl[p][CTL_TX_DISABLE];
        assign led_disable[p] = ctrl[p][CTL_LED_DISABLE];
    end

    assign far_end_fault_disable = ctrl[0][CTL_FEF_DISABLE]; // see R12

    // switch-side read shows the same state as the management register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_rd_data <= '0;
        end else begin
            sw_rd_data <= '0;
            for (int p = 0; p < 2; p++) begin
                if (sw_addr == SW_AN_ADDR[p]) begin
                    sw_rd_data <= {ctrl[p][CTL_AUTONEG_ENABLE], ctrl[p][CTL_FORCE_100],
                                   ctrl[p][CTL_FULL_DUPLEX], 5'h00};
                end
                if (sw_addr == SW_CTL_ADDR[p]) begin
                    sw_rd_data <= {ctrl[p][CTL_LED_DISABLE], ctrl[p][CTL_TX_DISABLE],
                                   ctrl[p][CTL_AUTONEG_RESTART], ctrl[p][CTL_FEF_DISABLE],
                                   ctrl[p][CTL_POWER_DOWN], ctrl[p][CTL_XOVER_DISABLE],
                                   ctrl[p][CTL_FORCE_STRAIGHT], ctrl[p][CTL_LOOPBACK]};
                end
                if (sw_addr == SW_XOVER_ADDR[p]) begin
                    sw_rd_data <= {ctrl[p][CTL_ALT_XOVER], 7'h00};
                end
            end
            if (sw_addr == SW_PHY_BASE_ADDR) begin
                sw_rd_data <= {phy_base_reg, 3'h0};
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    wire read_start = mdc_rise && state_reg == S_TA && bit_cnt_reg == '0
        && frame_hit && frame_ok == OP_READ;

    status_value_a: assert property (read_start && reg_of_frame == REG_BASIC_STATUS // see R15 see R16
        |=> rd_shift_reg == STATUS_VALUE && !rd_shift_reg[15])
        else $error("status read did not load the fixed capability value");
    ta_drive_a: assert property (read_start |=> !mdio_oe_n && !mdio_out) // see R1
        else $error("addressed read did not drive zero in turnaround");
    miss_quiet_a: assert property (!mdio_oe_n |-> rd_hit_reg) // see R1
        else $error("mdio driven without an addressed read");
    restart_clear_a: assert property (autoneg_restart[0] && !mii_wr_reg[0] // see R7
        && !(sw_wr_en && sw_addr == SW_CTL_ADDR[0]) |=> !autoneg_restart[0])
        else $error("restart request did not clear itself");
    speed_mirror_a: assert property (sw_wr_en && sw_addr == SW_AN_ADDR[0] // see R4
        |=> force_100[0] == $past(sw_wdata[6]))
        else $error("speed bit did not follow switch register write");
    an_mirror_a: assert property (sw_wr_en && sw_addr == SW_AN_ADDR[1] // see R5
        |=> autoneg_enable[1] == $past(sw_wdata[7]))
        else $error("port two autoneg bit did not follow switch write");
    loop_one_a: assert property (sw_wr_en && sw_addr == SW_CTL_ADDR[0] // see R2
        |=> far_end_loopback[0] == $past(sw_wdata[0]))
        else $error("port one loopback did not follow switch write");
    loop_two_a: assert property (sw_wr_en && sw_addr == SW_CTL_ADDR[1] // see R3
        |=> far_end_loopback[1] == $past(sw_wdata[0]))
        else $error("port two loopback did not follow switch write");
    fef_port_two_a: assert property (sw_addr == SW_CTL_ADDR[1] && !sw_wr_en // see R12
        |=> !sw_rd_data[4])
        else $error("port two shows a far-end fault disable bit");
    power_view_a: assert property (sw_addr == SW_CTL_ADDR[0] // see R6
        |=> sw_rd_data[3] == $past(power_down[0]))
        else $error("switch view of power down differs from control bit");
    unused_bits_a: assert property (mii_wr_reg[1] // see R17
        |=> ctrl[1][15] == 1'b0 && ctrl[1][10] == 1'b0 && ctrl[1][7:6] == 2'b00)
        else $error("unsupported control bits took a write");
    // switch writes land one cycle later and win over a same-cycle frame write
    duplex_mirror_a: assert property (sw_wr_en && sw_addr == SW_AN_ADDR[0] // see R8
        |=> full_duplex[0] == $past(sw_wdata[5]))
        else $error("duplex bit did not follow switch write");
    xover_mirror_a: assert property (sw_wr_en && sw_addr == SW_XOVER_ADDR[0] // see R9
        |=> alt_crossover_algorithm_sel[0] == $past(sw_wdata[7]))
        else $error("crossover algorithm bit did not follow switch write");
    straight_mirror_a: assert property (sw_wr_en && sw_addr == SW_CTL_ADDR[1] // see R10
        |=> force_straight_wiring[1] == $past(sw_wdata[1]))
        else $error("straight wiring bit did not follow switch write");
    xover_off_a: assert property (sw_wr_en && sw_addr == SW_CTL_ADDR[0] // see R11
        |=> crossover_detect_disable[0] == $past(sw_wdata[2]))
        else $error("crossover disable bit did not follow switch write");
    tx_off_a: assert property (sw_wr_en && sw_addr == SW_CTL_ADDR[1] // see R13
        |=> tx_disable[1] == $past(sw_wdata[6]))
        else $error("transmit disable bit did not follow switch write");
    led_off_a: assert property (sw_wr_en && sw_addr == SW_CTL_ADDR[0] // see R14
        |=> led_disable[0] == $past(sw_wdata[7]))
        else $error("led disable bit did not follow switch write");

    read_frame_c: cover property (read_start ##1 !mdio_oe_n [*3]);
    write_frame_c: cover property (mii_wr_reg[1]);
    sw_ctl_write_c: cover property (sw_wr_en && sw_addr == SW_CTL_ADDR[0]);
    remap_c: cover property (sw_wr_en && sw_addr == SW_PHY_BASE_ADDR);
    restart_c: cover property (autoneg_restart[1]);
endmodule
`default_nettype wire

// ==== tb/mdio_host.sv ====
// management host model driving the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module mdio_host import phy_regs_pkg::*; (
    // serial pins
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_n
);
    logic host_oe = 1'b0;
    logic host_d = 1'b1;
    initial mdc = 1'b0;
    // pulled-up line: reads high whenever nobody drives it
    assign mdio_in = host_oe ? host_d : (mdio_oe_n ? 1'b1 : mdio_out);

    // clock stands low between bits, so it is still outside frames
    task automatic bit_cyc(input logic drv, input logic d, output logic s);
        host_oe = drv;
        host_d = d;
        #62.5 mdc = 1'b1;
        s = mdio_in;
        #62.5 mdc = 1'b0;
    endtask

    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] idx, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] seq;
        logic s;
        seq = {FRAME_START, op, phy, idx, 2'b10, wd};
        for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
        // reads release the line from the turnaround on
        for (int i = 31; i >= 0; i--) begin
            bit_cyc(i > 17 || op == OP_WRITE, seq[i], s);
            if (i < 16) rd[i] = s;
        end
        host_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_phy_basic_regs.sv ====
// self-checking bench for the phy basic control and status registers
`timescale 1ns/1ps
`default_nettype none
module test_phy_basic_regs import phy_regs_pkg::*; ;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sw_wr_en = 1'b0;
    logic [7:0] sw_addr = 8'h00;
    logic [7:0] sw_wdata = 8'h00;
    logic [7:0] sw_rd_data;
    logic mdc, mdio_in, mdio_out, mdio_oe_n, fef;
    logic [1:0] lb, f100, an, pd, rs, fd, alt, st, xd, txd, led;
    logic [7:0] rs_cnt = 8'h00;
    int n_mismatch = 0;
    int compares = 0;

    always #4 clock = ~clock;
    // restart is a one-cycle pulse, so count the pulses of each port in a nibble
    always @(posedge clock) rs_cnt <= rs_cnt + {3'h0, rs[1], 3'h0, rs[0]};

    phy_basic_regs dut (.clock(clock), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .sw_wr_en(sw_wr_en), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_rd_data(sw_rd_data), .far_end_loopback(lb),
        .force_100(f100), .autoneg_enable(an), .power_down(pd), .autoneg_restart(rs),
        .full_duplex(fd), .alt_crossover_algorithm_sel(alt), .force_straight_wiring(st),
        .crossover_detect_disable(xd), .tx_disable(txd), .led_disable(led),
        .far_end_fault_disable(fef));
    mdio_host host (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        sw_wr_en = 1'b1;
        sw_addr = a;
        sw_wdata = d;
        @(posedge clock) #1;
        sw_wr_en = 1'b0;
    endtask

    task automatic sw_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock) #1;
        sw_addr = a;
        @(posedge clock) #1;
        chk({8'h00, sw_rd_data}, {8'h00, exp});
    endtask

    task automatic mrd(input logic [4:0] phy, input logic [4:0] idx, input logic [15:0] exp);
        logic [15:0] rd;
        host.frame(32, OP_READ, phy, idx, 16'h0000, rd);
        chk(rd, exp);
    endtask

    task automatic mwr(input int pre, input logic [4:0] phy, input logic [4:0] idx,
                       input logic [15:0] wd);
        logic [15:0] rd;
        host.frame(pre, OP_WRITE, phy, idx, wd, rd);
        repeat (8) @(posedge clock);
    endtask

    // control image rebuilt from the output levels, restart left out
    function automatic logic [15:0] img(input int p);
        return {1'b0, lb[p], f100[p], an[p], pd[p], 2'b00, fd[p], 2'b00, alt[p], st[p],
                xd[p], p == 0 ? fef : 1'b0, txd[p], led[p]};
    endfunction

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic end_sim;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_mismatch++;
        end_sim;
    end

    initial begin
        repeat (20) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clock);
        for (int p = 0; p < 2; p++) begin
            mrd(5'(p + 1), REG_BASIC_CONTROL, 16'h1020);
            mrd(5'(p + 1), REG_BASIC_STATUS, 16'h7000);
            chk(img(p), 16'h1020);
        end
        sw_rd(8'h1c, 8'h80);
        sw_rd(8'h1f, 8'h80);
        done("reset");
        mwr(32, 5'h01, REG_BASIC_CONTROL, 16'hffff);
        mrd(5'h01, REG_BASIC_CONTROL, 16'h793f);
        chk(img(0), 16'h793f);
        sw_rd(8'h1c, 8'he0);
        sw_rd(8'h1d, 8'hdf);
        mwr(32, 5'h02, REG_BASIC_CONTROL, 16'hffff);
        mrd(5'h02, REG_BASIC_CONTROL, 16'h793b);
        chk(img(1), 16'h793b);
        chk({8'h00, rs_cnt}, 16'h0011);
        sw_rd(8'h2d, 8'hcf);
        done("mdio write");
        mwr(32, 5'h01, REG_BASIC_CONTROL, 16'h0000);
        sw_wr(8'h1d, 8'h01);
        sw_wr(8'h1c, 8'h60);
        sw_wr(8'h1f, 8'h00);
        mrd(5'h01, REG_BASIC_CONTROL, 16'h6100);
        chk(img(0), 16'h6100);
        chk({8'h00, rs_cnt}, 16'h0011);
        sw_wr(8'h2c, 8'he0);
        sw_wr(8'h2d, 8'hb8);
        sw_rd(8'h2d, 8'h88);
        chk(img(1), 16'h3921);
        chk({8'h00, rs_cnt}, 16'h0021);
        mrd(5'h02, REG_BASIC_CONTROL, 16'h3921);
        done("switch write");
        mwr(32, 5'h01, REG_BASIC_STATUS, 16'h0000);
        mrd(5'h01, REG_BASIC_STATUS, 16'h7000);
        // a 31-one preamble must not open a frame
        mwr(31, 5'h01, REG_BASIC_CONTROL, 16'hffff);
        mrd(5'h01, REG_BASIC_CONTROL, 16'h6100);
        sw_wr(8'h30, 8'hff);
        sw_rd(8'h30, 8'h00);
        done("refusals");
        sw_wr(8'h0f, 8'h2f);
        sw_rd(8'h0f, 8'h28);
        mrd(5'h05, REG_BASIC_CONTROL, 16'h6100);
        mrd(5'h06, REG_BASIC_CONTROL, 16'h3921);
        mrd(5'h01, REG_BASIC_CONTROL, 16'hffff);
        done("address remap");
        end_sim;
    end
endmodule
`default_nettype wire
